//--- inc/pans_regs.svh
`ifndef PANS_REGS_SVH
`define PANS_REGS_SVH
// ----------------------------------------
// register offsets, per port block; irq status and mask only in the port 1 block
// ----------------------------------------
`define PANS_PORT_STRIDE 12'h100
`define PANS_PORT1_BASE 12'h100
// register index within a port block; byte address is four times it
`define PANS_IDX_ADVERT 8'h04
`define PANS_IDX_PARTNER 8'h05
`define PANS_IDX_EXPANSION 8'h06
`define PANS_IDX_NEXT_PAGE 8'h07
`define PANS_OFF_ADVERT 8'h10
`define PANS_OFF_PARTNER 8'h14
`define PANS_OFF_EXPANSION 8'h18
`define PANS_OFF_NEXT_PAGE 8'h1c
`define PANS_OFF_IRQ_STATUS 8'h40
`define PANS_OFF_IRQ_MASK 8'h44
// ----------------------------------------
// field positions
// ----------------------------------------
`define PANS_ADV_NEXT_PAGE 15
`define PANS_ADV_REMOTE_FAULT 13
`define PANS_LP_ACK 14
`define PANS_EXP_PD_FAULT 4
`define PANS_EXP_LP_NP_ABLE 3
`define PANS_EXP_NP_ABLE 2
`define PANS_EXP_PAGE_RX 1
`define PANS_EXP_LP_AN_ABLE 0
// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define PANS_ADV_RESET 16'h05e1
`define PANS_ADV_WMASK 16'hadff
`define PANS_NP_RESET 16'h2001
`define PANS_NP_WMASK 16'hb7ff
`endif

//--- inc/pans_pkg.sv
package pans_pkg;
    typedef struct packed {
        logic page_valid;
        logic [15:0] page_word;
        logic parallel_fault;
        logic partner_an_able;
        logic toggle;
    } pans_phy_in_type;

    typedef struct packed {
        logic [15:0] advert;
        logic [15:0] next_page;
    } pans_phy_out_type;

    typedef enum logic [1:0] {
        PANS_IDLE = 2'b00,
        PANS_ACCESS = 2'b01
    } pans_state_type;

    typedef struct packed {
        pans_state_type state;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [1:0][15:0] advert;
        logic [1:0][15:0] next_page;
        logic [1:0][15:0] partner;
        logic [1:0] partner_seen;
        logic [1:0] pd_fault;
        logic [1:0] page_rx;
        logic [1:0] lp_an_able;
        logic [1:0] toggle;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic [1:0][2:0] sync_fault;
        logic [1:0][2:0] sync_able;
        logic [1:0] fault_q;
        logic [1:0] able_q;
    } pans_state_struct_type;
endpackage

//--- logic/pans_regs_top.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "pans_regs.svh"
module pans_regs_top
    import pans_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire pans_phy_in_type phy_in [2],
    output pans_phy_out_type phy_out [2]
);
    pans_state_struct_type s;
    pans_state_struct_type next_s;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic [2:0] decode(input logic [11:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a[11:8] == 4'h1 || a[11:8] == 4'h2)
        begin
            r[2] = (a[11:8] == 4'h2);
            r[1:0] = 2'h3;
            if (a[7:0] == `PANS_OFF_ADVERT) r = {r[2], 2'h0};
            else if (a[7:0] == `PANS_OFF_PARTNER) r = {r[2], 2'h1};
            else if (a[7:0] == `PANS_OFF_EXPANSION) r = {r[2], 2'h2};
            else if (a[7:0] == `PANS_OFF_NEXT_PAGE) r = {r[2], 2'h3};
            else r = 3'h0;
        end
        return r;
    endfunction

    function automatic logic hit(input logic [11:0] a);
        return (a[11:8] == 4'h1 || a[11:8] == 4'h2) &&
            (a[7:0] == `PANS_OFF_ADVERT || a[7:0] == `PANS_OFF_PARTNER ||
             a[7:0] == `PANS_OFF_EXPANSION || a[7:0] == `PANS_OFF_NEXT_PAGE);
    endfunction

    function automatic logic [15:0] expansion(input pans_state_struct_type t, input int p);
        logic [15:0] e;
        e = 16'h0000;
        e[`PANS_EXP_PD_FAULT] = t.pd_fault[p];
        e[`PANS_EXP_LP_NP_ABLE] = t.partner[p][`PANS_ADV_NEXT_PAGE];
        e[`PANS_EXP_NP_ABLE] = t.advert[p][`PANS_ADV_NEXT_PAGE];
        e[`PANS_EXP_PAGE_RX] = t.page_rx[p];
        e[`PANS_EXP_LP_AN_ABLE] = t.lp_an_able[p];
        return e;
    endfunction

    logic [2:0] sel;
    logic is_irq_st;
    logic is_irq_mk;
    logic wr;
    logic rd;

    always_comb
    begin
        next_s = s;
        sel = decode(paddr);
        is_irq_st = (paddr == `PANS_PORT1_BASE + {4'h0, `PANS_OFF_IRQ_STATUS});
        is_irq_mk = (paddr == `PANS_PORT1_BASE + {4'h0, `PANS_OFF_IRQ_MASK});
        wr = 1'b0;
        rd = 1'b0;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.prdata = 32'h0000_0000;
        // ----------------------------------------
        // apb slave, one wait state
        // ----------------------------------------
        unique case (s.state)
            PANS_IDLE:
            begin
                if (psel && !penable)
                begin
                    next_s.state = PANS_ACCESS;
                end
            end
            PANS_ACCESS:
            begin
                if (psel && penable && !s.pready)
                begin
                    next_s.pready = 1'b1;
                    next_s.pslverr = !(hit(paddr) || is_irq_st || is_irq_mk);
                    wr = pwrite;
                    rd = !pwrite;
                end
                if (s.pready)
                begin
                    next_s.state = PANS_IDLE;
                end
            end
            default:
            begin
                next_s.state = PANS_IDLE;
            end
        endcase

        // ----------------------------------------
        // read data
        // ----------------------------------------
        if (rd)
        begin
            next_s.prdata = 32'h0000_0000;
            if (is_irq_st) next_s.prdata = {28'h0, s.irq_status};
            else if (is_irq_mk) next_s.prdata = {28'h0, s.irq_mask};
            else if (hit(paddr))
            begin
                unique case (sel[1:0])
                    2'h0: next_s.prdata = {16'h0, s.advert[sel[2]]};
                    2'h1: next_s.prdata = {16'h0, s.partner[sel[2]]};
                    2'h2: next_s.prdata = {16'h0, expansion(s, int'(sel[2]))};
                    2'h3: next_s.prdata = {16'h0, s.next_page[sel[2]][15:12],
                        s.toggle[sel[2]], s.next_page[sel[2]][10:0]};
                endcase
            end
        end

        // ----------------------------------------
        // per-port phy status
        // ----------------------------------------
        for (int p = 0; p < 2; p++)
        begin
            next_s.sync_fault[p] = {s.sync_fault[p][1:0], phy_in[p].parallel_fault};
            next_s.sync_able[p] = {s.sync_able[p][1:0], phy_in[p].partner_an_able};
            if (s.sync_fault[p][2] == s.sync_fault[p][1])
                next_s.fault_q[p] = s.sync_fault[p][2];
            if (s.sync_able[p][2] == s.sync_able[p][1])
                next_s.able_q[p] = s.sync_able[p][2];
            next_s.lp_an_able[p] = s.able_q[p];
            // clear-on-read of latched flags, the set wins
            if (rd && hit(paddr) && sel[1:0] == 2'h2 && int'(sel[2]) == p)
            begin
                next_s.pd_fault[p] = 1'b0;
                next_s.page_rx[p] = 1'b0;
            end
            if (s.fault_q[p])
            begin
                next_s.pd_fault[p] = 1'b1;
            end
            if (phy_in[p].page_valid)
            begin
                next_s.page_rx[p] = 1'b1;
                next_s.partner_seen[p] = 1'b1;
                next_s.toggle[p] = phy_in[p].toggle;
                next_s.partner[p] = phy_in[p].page_word;
                next_s.partner[p][`PANS_LP_ACK] = 1'b1;
            end
            if (wr && hit(paddr) && int'(sel[2]) == p)
            begin
                if (sel[1:0] == 2'h0)
                    next_s.advert[p] = (pwdata[15:0] & `PANS_ADV_WMASK) |
                        (s.advert[p] & ~`PANS_ADV_WMASK);
                if (sel[1:0] == 2'h3)
                    next_s.next_page[p] = (pwdata[15:0] & `PANS_NP_WMASK) |
                        (s.next_page[p] & ~`PANS_NP_WMASK);
            end
        end

        // ----------------------------------------
        // interrupts: page received, parallel fault
        // ----------------------------------------
        if (wr && is_irq_st) next_s.irq_status = s.irq_status & ~pwdata[3:0];
        if (wr && is_irq_mk) next_s.irq_mask = pwdata[3:0];
        for (int p = 0; p < 2; p++)
        begin
            if (phy_in[p].page_valid) next_s.irq_status[2 * p] = 1'b1;
            if (s.fault_q[p] && !s.pd_fault[p]) next_s.irq_status[2 * p + 1] = 1'b1;
        end
        next_s.irq = |(next_s.irq_status & s.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.state <= PANS_IDLE;
            s.advert <= {`PANS_ADV_RESET, `PANS_ADV_RESET};
            s.next_page <= {`PANS_NP_RESET, `PANS_NP_RESET};
        end
        else if (clk_en)
        begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            phy_out[p].advert = s.advert[p];
            phy_out[p].next_page = {s.next_page[p][15:12], s.toggle[p], s.next_page[p][10:0]};
        end
    end
endmodule

//--- dv/pans_phy_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// remote partner: pages and status levels
// ----------------------------------------
module pans_phy_model
    import pans_pkg::*;
(
    input wire logic pclk,
    output pans_phy_in_type phy_in [2]
);
    initial phy_in = '{default: '0};
    task send_page(input int p, input logic [15:0] w);
        @(posedge pclk);
        phy_in[p].page_word <= w;
        phy_in[p].page_valid <= 1'b1;
        @(posedge pclk);
        phy_in[p].page_valid <= 1'b0;
        phy_in[p].page_word <= ~w;
    endtask
    task set_lvl(input int p, input logic f, input logic a, input logic t);
        @(posedge pclk);
        phy_in[p].parallel_fault <= f;
        phy_in[p].partner_an_able <= a;
        phy_in[p].toggle <= t;
    endtask
endmodule

//--- dv/pans_regs_top_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks
// ----------------------------------------
module pans_regs_top_asserts
    import pans_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pans_phy_out_type phy_out [2]
);
    logic rd;
    assign rd = pready && !pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ACC: assert property (pready |-> $past(psel && penable))
        else $error("answer without access");
    AST_PLS: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_UPR: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_ZRO: assert property (((phy_out[0].advert | phy_out[1].advert) & 16'h5200) == 0)
        else $error("read-only advert bit set");
    AST_ADV: assert property (rd && paddr == 12'h110 |-> prdata[15:0] == phy_out[0].advert)
        else $error("advert read differs");
    AST_NPG: assert property (rd && paddr == 12'h11c |-> prdata[15:0] == phy_out[0].next_page)
        else $error("next page read differs");
    AST_EXP: assert property (rd && paddr == 12'h118 |->
        prdata[15:5] == 11'h000 && prdata[2] == phy_out[0].advert[15])
        else $error("expansion read wrong");
    AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer carries data");
endmodule
bind pans_regs_top pans_regs_top_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phy_out(phy_out));

//--- dv/pans_regs_top_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// register tests over apb
// ----------------------------------------
module pans_regs_top_bench
    import pans_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic pready, pslverr, irq;
    pans_phy_in_type phy_in [2];
    pans_phy_out_type phy_out [2];
    int err_count = 0, cmp_count = 0, cyc = 0;
    pans_regs_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .phy_in(phy_in), .phy_out(phy_out));
    pans_phy_model phy_u (.pclk(pclk), .phy_in(phy_in));
    initial forever #12.5 pclk = ~pclk;
    task end_of_test();
        $display("mismatches %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(12'h110, 32'h05e1);
        rc(12'h210, 32'h05e1);
        rc(12'h11c, 32'h2001);
        rc(12'h114, 32'h0000);
        apb(1'b1, 12'h110, 32'hffff);
        rc(12'h110, 32'hadff);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'h110, {20'h0, i[1:0], 10'h1e1});
            rc(12'h110, {20'h0, i[1:0], 10'h1e1});
        end
        apb(1'b1, 12'h11c, 32'hffff);
        rc(12'h11c, 32'hb7ff);
        apb(1'b1, 12'h11c, 32'h0);
        apb(1'b1, 12'h114, 32'hffff);
        rc(12'h114, 32'h0000);
        phy_u.set_lvl(0, 1'b0, 1'b1, 1'b1);
        repeat (8) @(posedge pclk);
        rc(12'h11c, 32'h0000);
        $display("test fields done");
        apb(1'b1, 12'h110, 32'h85e1);
        phy_u.send_page(0, 16'h9de1);
        repeat (4) @(posedge pclk);
        rc(12'h114, 32'hdde1);
        rc(12'h11c, 32'h0800);
        rc(12'h118, 32'h000f);
        rc(12'h118, 32'h000d);
        phy_u.set_lvl(0, 1'b1, 1'b1, 1'b1);
        repeat (8) @(posedge pclk);
        phy_u.set_lvl(0, 1'b0, 1'b1, 1'b1);
        repeat (8) @(posedge pclk);
        rc(12'h118, 32'h001d);
        rc(12'h118, 32'h000d);
        $display("test partner done");
        apb(1'b1, 12'h140, 32'hf);
        apb(1'b1, 12'h144, 32'h5);
        chk({31'h0, irq}, 32'h0);
        phy_u.send_page(1, 16'h0001);
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rc(12'h140, 32'h4);
        rc(12'h218, 32'h2);
        apb(1'b1, 12'h144, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h144, 32'h4);
        apb(1'b1, 12'h140, 32'h4);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 12'h0f0, 32'h0);
        chk({31'h0, se}, 32'h1);
        $display("test irq done");
        end_of_test();
    end
endmodule
